// file: rtl/iex_pkg.sv
// Purpose: Shared constants and types of the interrupt and exception unit.
// Assumes: 100 MHz aclk, synchronous active-low reset, AXI4-Lite register access.
// Notes: Register map and field positions live here only.
// Operation
// (RQ1) Maskable requests need the global enable set; order follows programmable levels.
// (RQ2) Non-maskable requests ignore the global enable; their order is fixed.
// (RQ3) Trap instructions raise software interrupts that cannot be masked.
// (RQ4) The undefined-opcode instruction raises the undefined instruction interrupt.
// (RQ5) Overflow-trap instruction traps only while the overflow flag is one.
// (RQ6) Overflow flag is updated only by the listed arithmetic instruction groups.
// (RQ7) The break instruction raises the break interrupt.
// (RQ8) Software interrupt instruction selects numbers 0 to 63 and uses that entry.
// (RQ9) Numbers 3 to 31 share the peripheral vectors and handlers.
// (RQ10) Numbers 0 to 31 save the stack-select flag, clear it, restore on return.
// (RQ11) Numbers 32 to 63 leave the stack-select flag untouched.
// (RQ12) Watchdog, oscillation stop and both voltage monitors are non-maskable.
// (RQ13) An enabled address match traps just before the instruction at that address.
// (RQ14) Software leaves single-step and address break interrupts to debug tools.
// (RQ15) Peripheral requests are maskable.
// (RQ16) Each vector entry is four bytes holding the handler start address.
// (RQ17) On acceptance the unit branches to the handler read from the vector.
// (RQ18) Fixed vectors sit in a dedicated region at the top of the map; the code puts them at 0ffdc, the top of the first 64 KB of the 20-bit map.
// (RQ19) Relocatable vectors form a 256-byte table at the table base register.
// (RQ20) Oscillation stop, watchdog and voltage monitors share one vector.
// (RQ21) Among maskable requests the highest level wins; ties go to lowest source.
package iex_pkg;
  localparam int VEC_AW = 20;
  localparam int VEC_BYTES = 4;
  localparam int VEC_SHIFT = 2;
  localparam int RELOC_BYTES = 256;
  localparam int INT_NUM_W = $clog2(RELOC_BYTES / VEC_BYTES);
  localparam logic [VEC_AW-1:0] FIX_VEC_BASE = 20'h0ffdc;
  localparam logic [2:0] FIX_UND = 3'h0;
  localparam logic [2:0] FIX_OVF = 3'h1;
  localparam logic [2:0] FIX_BRK = 3'h2;
  localparam logic [2:0] FIX_MATCH = 3'h3;
  localparam logic [2:0] FIX_SPECIAL = 3'h5;
  localparam logic [INT_NUM_W-1:0] U_KEEP_FIRST = 6'h20;
  localparam int PERIPH_FIRST = 3;
  localparam logic [7:0] BRK_RELOC_MARK = 8'hff;
  localparam logic [INT_NUM_W-1:0] BRK_RELOC_NUM = 6'h00;
  localparam int LVL_W = 3;
  localparam int LVL_STRIDE = 4;
  localparam int LVL_PER_WORD = 8;
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_VTB = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_AMEN = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_MAA = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_MAB = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_STAT = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_LVL = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTRL_IEN_BIT = 0;
  localparam int CTRL_U_BIT = 1;
  localparam int CTRL_IPL_LSB = 4;
  localparam int STAT_NUM_LSB = 0;
  localparam int STAT_CLASS_LSB = 8;
  localparam int STAT_BUSY_BIT = 12;
  localparam int STAT_OVF_BIT = 13;
  localparam int STAT_SRC_LSB = 16;

  typedef enum logic [2:0] {
    IK_NONE = 3'h0, IK_UND = 3'h1, IK_INTO = 3'h2, IK_BRK = 3'h3, IK_INT = 3'h4
  } iex_instr_t;

  typedef enum logic [3:0] {
    AG_OTHER = 4'h0, AG_ABS = 4'h1, AG_ADD = 4'h2, AG_ADC = 4'h3, AG_CMP = 4'h4,
    AG_DIV = 4'h5, AG_NEG = 4'h6, AG_MAC = 4'h7, AG_SBB = 4'h8, AG_SHA = 4'h9,
    AG_SUB = 4'ha
  } iex_arith_t;

  typedef enum logic [2:0] {
    CL_NONE = 3'h0, CL_UND = 3'h1, CL_OVF = 3'h2, CL_BRK = 3'h3, CL_INT = 3'h4,
    CL_MATCH = 3'h5, CL_SPECIAL = 3'h6, CL_PERIPH = 3'h7
  } iex_class_t;

  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_FETCH = 1'b1} iex_state_t;

  function automatic logic ovf_updating(input iex_arith_t g);
    return g != AG_OTHER;
  endfunction
endpackage

// file: rtl/iex_prio_arb.sv
// Purpose: Picks the maskable request with the highest priority level.
// Assumes: Level zero means the source is disabled.
// Notes: Ties resolve to the lowest source index, a fixed order.
module iex_prio_arb #(
  parameter int N = 32,
  parameter int IW = $clog2(N)
) (
  input logic [N-1:0] req,
  input logic [N*iex_pkg::LVL_W-1:0] lvl_flat,
  input logic [iex_pkg::LVL_W-1:0] floor_lvl,
  output logic hit,
  output logic [IW-1:0] idx,
  output logic [iex_pkg::LVL_W-1:0] level
);
  import iex_pkg::*;

  always_comb begin
    logic [LVL_W-1:0] l;
    l = '0;
    hit = 1'b0;
    idx = '0;
    level = floor_lvl;
    // Strict greater-than keeps the earlier index on a tie
    for (int i = 0; i < N; i++) begin
      l = lvl_flat[i*LVL_W +: LVL_W];
      if (req[i] && l > level) begin // RQ21
        hit = 1'b1;
        idx = IW'(i);
        level = l;
      end
    end
  end
endmodule

// file: rtl/iex_unit.sv
// Purpose: Interrupt and exception acceptance, vector fetch and branch.
// Assumes: Core presents one instruction event at a time and waits on exc_ready.
// Notes: Vector memory answers vec_req with vec_ack and data in the same cycle.
//
// Added by the designer: the address map and register access over AXI4-Lite.
module iex_unit #(
  parameter int N_PERIPH = 32
) (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [iex_pkg::AXI_AW-1:0] s_axi_awaddr,
  input logic [2:0] s_axi_awprot,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  input logic [iex_pkg::AXI_AW-1:0] s_axi_araddr,
  input logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input logic instr_valid,
  input iex_pkg::iex_instr_t instr_kind,
  input logic [iex_pkg::INT_NUM_W-1:0] instr_int_num,
  output logic exc_ready,
  input logic arith_valid,
  input iex_pkg::iex_arith_t arith_group,
  input logic arith_ovf,
  input logic fetch_valid,
  input logic [iex_pkg::VEC_AW-1:0] fetch_addr,
  input logic reti_valid,
  input logic reti_u,
  input logic reti_i,
  input logic [iex_pkg::LVL_W-1:0] reti_ipl,
  input logic [N_PERIPH-1:0] periph_req,
  output logic [N_PERIPH-1:0] periph_ack,
  input logic wdt_req,
  input logic osc_stop_req,
  input logic vmon1_req,
  input logic vmon2_req,
  output logic vec_req,
  output logic [iex_pkg::VEC_AW-1:0] vec_addr,
  input logic vec_ack,
  input logic [31:0] vec_data,
  output logic branch_valid,
  output logic [iex_pkg::VEC_AW-1:0] branch_addr,
  output logic stack_push_u,
  output logic stack_sel,
  output logic ovf_flag,
  output logic irq_enable
);
  import iex_pkg::*;
  localparam int IW = $clog2(N_PERIPH);
  localparam int LVL_WORDS = (N_PERIPH + LVL_PER_WORD - 1) / LVL_PER_WORD;

  function automatic logic [VEC_AW-1:0] fix_vec(input logic [2:0] n);
    return FIX_VEC_BASE + VEC_AW'({n, {VEC_SHIFT{1'b0}}});
  endfunction

  function automatic logic [VEC_AW-1:0] reloc_vec(input logic [VEC_AW-1:0] base,
                                                  input logic [INT_NUM_W-1:0] n);
    return base + VEC_AW'({n, {VEC_SHIFT{1'b0}}});
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [AXI_AW-1:0] lvl_ofs(input int w);
    return OFS_LVL + AXI_AW'(w * 4);
  endfunction

  iex_state_t st;
  logic [LVL_W-1:0] ipl;
  logic [VEC_AW-1:0] vtb;
  logic [1:0] amen;
  logic [VEC_AW-1:0] maa;
  logic [VEC_AW-1:0] mab;
  logic [LVL_W-1:0] lvl [N_PERIPH];
  logic [N_PERIPH*LVL_W-1:0] lvl_flat;
  iex_class_t acc_class;
  logic [INT_NUM_W-1:0] acc_num;
  logic brk_check;
  logic aw_full;
  logic w_full;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic wr_ok;
  logic [31:0] rd_word;
  logic rd_ok;
  logic sw_trap;
  logic match_hit;
  logic special_req;
  logic arb_hit;
  logic [IW-1:0] arb_idx;
  logic [LVL_W-1:0] arb_lvl;
  logic mask_ok;
  logic accept;
  logic brk_redirect;
  iex_class_t next_class;
  logic [INT_NUM_W-1:0] next_num;
  logic [VEC_AW-1:0] next_vec;
  logic [31:0] vtb_m, amen_m, maa_m, mab_m;

  // ---------------- Register slave ----------------
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_ok = aw_addr_q == OFS_CTRL || aw_addr_q == OFS_VTB || aw_addr_q == OFS_AMEN ||
            aw_addr_q == OFS_MAA || aw_addr_q == OFS_MAB;
    for (int w = 0; w < LVL_WORDS; w++) begin
      if (aw_addr_q == lvl_ofs(w)) begin
        wr_ok = 1'b1;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      OFS_CTRL: begin
        rd_word[CTRL_IEN_BIT] = irq_enable;
        rd_word[CTRL_U_BIT] = stack_sel;
        rd_word[CTRL_IPL_LSB +: LVL_W] = ipl;
      end
      OFS_VTB: rd_word[VEC_AW-1:0] = vtb;
      OFS_AMEN: rd_word[1:0] = amen;
      OFS_MAA: rd_word[VEC_AW-1:0] = maa;
      OFS_MAB: rd_word[VEC_AW-1:0] = mab;
      OFS_STAT: begin
        rd_word[STAT_NUM_LSB +: INT_NUM_W] = acc_num;
        rd_word[STAT_CLASS_LSB +: 3] = acc_class;
        rd_word[STAT_BUSY_BIT] = st == ST_FETCH;
        rd_word[STAT_OVF_BIT] = ovf_flag;
        // Shared special vector: handler reads the live causes here
        rd_word[STAT_SRC_LSB +: 4] = {vmon2_req, vmon1_req, osc_stop_req, wdt_req}; // RQ20
      end
      default: begin
        rd_ok = 1'b0;
        for (int i = 0; i < N_PERIPH; i++) begin
          if (s_axi_araddr == lvl_ofs(i / LVL_PER_WORD)) begin
            rd_ok = 1'b1;
            rd_word[(i % LVL_PER_WORD) * LVL_STRIDE +: LVL_W] = lvl[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign vtb_m = merge(32'(vtb), w_data_q, w_strb_q);
  assign amen_m = merge(32'(amen), w_data_q, w_strb_q);
  assign maa_m = merge(32'(maa), w_data_q, w_strb_q);
  assign mab_m = merge(32'(mab), w_data_q, w_strb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vtb <= '0;
      amen <= '0;
      maa <= '0;
      mab <= '0;
    end else if (do_write) begin
      if (aw_addr_q == OFS_VTB) begin
        vtb <= {vtb_m[VEC_AW-1:VEC_SHIFT], {VEC_SHIFT{1'b0}}};
      end
      if (aw_addr_q == OFS_AMEN) begin
        amen <= amen_m[1:0];
      end
      if (aw_addr_q == OFS_MAA) begin
        maa <= maa_m[VEC_AW-1:0];
      end
      if (aw_addr_q == OFS_MAB) begin
        mab <= mab_m[VEC_AW-1:0];
      end
    end
  end

  // Sources below the shared range stay at level zero and never win
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < N_PERIPH; i++) begin
        lvl[i] <= '0;
      end
    end else begin
      for (int i = PERIPH_FIRST; i < N_PERIPH; i++) begin
        if (do_write && aw_addr_q == lvl_ofs(i / LVL_PER_WORD) &&
            w_strb_q[(i % LVL_PER_WORD) / 2]) begin
          lvl[i] <= w_data_q[(i % LVL_PER_WORD) * LVL_STRIDE +: LVL_W];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N_PERIPH; i++) begin
      lvl_flat[i*LVL_W +: LVL_W] = lvl[i];
    end
  end

  // ---------------- Request selection ----------------
  iex_prio_arb #(.N(N_PERIPH), .IW(IW)) u_arb (
    .req(periph_req),
    .lvl_flat(lvl_flat),
    .floor_lvl(ipl),
    .hit(arb_hit),
    .idx(arb_idx),
    .level(arb_lvl)
  );

  assign sw_trap = instr_valid && (instr_kind == IK_UND || instr_kind == IK_BRK ||
                   instr_kind == IK_INT || (instr_kind == IK_INTO && ovf_flag)); // RQ3 RQ5
  assign match_hit = fetch_valid && ((amen[0] && fetch_addr == maa) ||
                                     (amen[1] && fetch_addr == mab)); // RQ13
  assign special_req = wdt_req || osc_stop_req || vmon1_req || vmon2_req; // RQ12
  assign mask_ok = irq_enable && arb_hit; // RQ1 RQ15

  // Fixed order: instruction traps, address match, special, then peripherals
  always_comb begin
    next_class = CL_NONE;
    next_num = '0;
    next_vec = '0;
    if (sw_trap) begin
      unique case (instr_kind)
        IK_UND: begin
          next_class = CL_UND;
          next_vec = fix_vec(FIX_UND); // RQ4
        end
        IK_INTO: begin
          next_class = CL_OVF;
          next_vec = fix_vec(FIX_OVF); // RQ5
        end
        IK_BRK: begin
          next_class = CL_BRK;
          next_vec = fix_vec(FIX_BRK); // RQ7
        end
        default: begin
          next_class = CL_INT;
          next_num = instr_int_num;
          next_vec = reloc_vec(vtb, instr_int_num); // RQ8 RQ9
        end
      endcase
    end else if (match_hit) begin
      next_class = CL_MATCH;
      next_vec = fix_vec(FIX_MATCH); // RQ18
    end else if (special_req) begin
      next_class = CL_SPECIAL;
      next_vec = fix_vec(FIX_SPECIAL); // RQ2 RQ20
    end else if (mask_ok) begin
      next_class = CL_PERIPH;
      next_num = INT_NUM_W'(arb_idx);
      next_vec = reloc_vec(vtb, INT_NUM_W'(arb_idx)); // RQ19
    end
  end

  assign exc_ready = st == ST_IDLE;
  assign accept = st == ST_IDLE && next_class != CL_NONE;
  assign vec_req = st == ST_FETCH;
  // Break whose fixed entry top byte is blank falls back to relocatable entry 0
  assign brk_redirect = brk_check && vec_data[31:24] == BRK_RELOC_MARK;

  // ---------------- Vector fetch and branch ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= ST_IDLE;
      vec_addr <= '0;
      brk_check <= 1'b0;
    end else begin
      unique case (st)
        ST_IDLE: begin
          if (accept) begin
            st <= ST_FETCH;
            vec_addr <= next_vec; // RQ16
            brk_check <= next_class == CL_BRK;
          end
        end
        ST_FETCH: begin
          if (vec_ack) begin
            brk_check <= 1'b0;
            if (brk_redirect) begin
              vec_addr <= reloc_vec(vtb, BRK_RELOC_NUM);
            end else begin
              st <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      branch_valid <= 1'b0;
      branch_addr <= '0;
    end else begin
      branch_valid <= st == ST_FETCH && vec_ack && !brk_redirect; // RQ17
      if (st == ST_FETCH && vec_ack) begin
        branch_addr <= vec_data[VEC_AW-1:0]; // RQ16
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_class <= CL_NONE;
      acc_num <= '0;
      periph_ack <= '0;
      stack_push_u <= 1'b0;
    end else begin
      periph_ack <= '0;
      if (accept) begin
        acc_class <= next_class;
        acc_num <= next_num;
        stack_push_u <= stack_sel; // RQ10
        if (next_class == CL_PERIPH) begin
          periph_ack <= N_PERIPH'(1) << arb_idx;
        end
      end
    end
  end

  // ---------------- Processor flags ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_sel <= 1'b0;
    end else if (accept && !(next_class == CL_INT && next_num >= U_KEEP_FIRST)) begin
      stack_sel <= 1'b0; // RQ10 RQ11
    end else if (reti_valid) begin
      stack_sel <= reti_u; // RQ10
    end else if (do_write && aw_addr_q == OFS_CTRL && w_strb_q[0]) begin
      stack_sel <= w_data_q[CTRL_U_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable <= 1'b0;
      ipl <= '0;
    end else if (accept) begin
      irq_enable <= 1'b0;
      if (next_class == CL_PERIPH) begin
        ipl <= arb_lvl; // RQ1
      end
    end else if (reti_valid) begin
      irq_enable <= reti_i;
      ipl <= reti_ipl;
    end else if (do_write && aw_addr_q == OFS_CTRL && w_strb_q[0]) begin
      irq_enable <= w_data_q[CTRL_IEN_BIT];
      ipl <= w_data_q[CTRL_IPL_LSB +: LVL_W];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_flag <= 1'b0;
    end else if (arith_valid && ovf_updating(arith_group)) begin
      ovf_flag <= arith_ovf; // RQ6
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  mask_gate_a: assert property (accept && next_class == CL_PERIPH |-> // RQ1
    irq_enable && arb_lvl > ipl ##1 ipl == $past(arb_lvl) && !irq_enable)
    else $error("maskable taken without enable or level");
  nmi_noflag_a: assert property (st == ST_IDLE && special_req && !sw_trap && // RQ2
    !match_hit |=> st == ST_FETCH && vec_addr == fix_vec(FIX_SPECIAL))
    else $error("special request not taken");
  und_vector_a: assert property (exc_ready && instr_valid && instr_kind == IK_UND |=> // RQ4
    vec_req && vec_addr == fix_vec(FIX_UND))
    else $error("undefined opcode not trapped");
  into_quiet_a: assert property (exc_ready && instr_valid && instr_kind == IK_INTO && // RQ5
    !ovf_flag && !match_hit && !special_req && !mask_ok |=> st == ST_IDLE)
    else $error("overflow trap without flag");
  ovf_hold_a: assert property (!(arith_valid && ovf_updating(arith_group)) |=> // RQ6
    $stable(ovf_flag))
    else $error("overflow flag changed without update");
  u_clear_a: assert property (accept && next_class == CL_INT && // RQ10
    next_num < U_KEEP_FIRST |=> !stack_sel && stack_push_u == $past(stack_sel))
    else $error("stack select not cleared");
  u_keep_a: assert property (accept && next_class == CL_INT && // RQ11
    next_num >= U_KEEP_FIRST && !reti_valid && !do_write |=> $stable(stack_sel))
    else $error("stack select changed for high number");
  int_entry_a: assert property (accept && next_class == CL_INT |=> // RQ8
    vec_addr == vtb + VEC_AW'({$past(instr_int_num), {VEC_SHIFT{1'b0}}}))
    else $error("software interrupt entry wrong");
  branch_data_a: assert property (st == ST_FETCH && vec_ack && !brk_redirect |=> // RQ17
    branch_valid && branch_addr == $past(vec_data[VEC_AW-1:0]) ##1 !branch_valid)
    else $error("branch address not from vector");
  match_trap_a: assert property (exc_ready && match_hit && !sw_trap |=> // RQ13
    acc_class == CL_MATCH && vec_addr == fix_vec(FIX_MATCH))
    else $error("address match not trapped");
endmodule

// file: verif/iex_vec_mem.sv
// Purpose: Vector memory behind the exception unit's fetch port.
// Assumes: Same-cycle answer; slow mode adds three wait cycles.
// Notes: Each entry word is a fixed function of its address, so answers are predictable.
module iex_vec_mem (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic vec_req,
  input wire logic [iex_pkg::VEC_AW-1:0] vec_addr,
  output logic vec_ack,
  output logic [31:0] vec_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import iex_pkg::*;
  logic [1:0] wait_cnt;
  logic [31:0] junk;
  always_ff @(posedge aclk) begin
    if (!aresetn || !vec_req) begin
      wait_cnt <= 2'h0;
    end else if (wait_cnt != 2'h3) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
  // Idle data toggles every cycle so a stale word never passes for an answer
  always_ff @(posedge aclk) begin
    junk <= aresetn ? ~junk : 32'h5a5a5a5a;
  end
  assign vec_ack = vec_req && (!slow || wait_cnt == 2'h3);
  assign vec_data = vec_ack ? {12'h0a5, vec_addr ^ 20'h0f0f0} : junk;
endmodule

// file: verif/test_cpu_interrupt_exception_unit.sv
// Purpose: Self-checking bench for the interrupt and exception unit.
// Assumes: Vector words come from the vector memory model at address xor 0f0f0.
// Notes: Core signals are driven by the bench tasks; request sources are raised directly in the main sequence and dropped by rel.
module test_cpu_interrupt_exception_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import iex_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, slow = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, vec_data, rdat;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic instr_valid = 1'h0, arith_valid = 1'h0, arith_ovf = 1'h0, fetch_valid = 1'h0;
  iex_instr_t instr_kind = IK_NONE;
  iex_arith_t arith_group = AG_OTHER;
  logic [5:0] instr_int_num = 6'h0;
  logic [19:0] fetch_addr = 20'h0, vec_addr, branch_addr;
  logic reti_valid = 1'h0, reti_u = 1'h0, reti_i = 1'h0;
  logic [2:0] reti_ipl = 3'h0;
  logic [31:0] periph_req = 32'h0, periph_ack, ackv;
  logic wdt_req = 1'h0, osc_stop_req = 1'h0, vmon1_req = 1'h0, vmon2_req = 1'h0;
  logic exc_ready, vec_req, vec_ack, branch_valid, stack_push_u, stack_sel;
  logic ovf_flag, irq_enable;
  int bad_count = 0;
  int samples_checked = 0;
  int nums[5] = '{3, 8, 31, 32, 63};

  iex_unit #(.N_PERIPH(32)) iex_unit_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .instr_valid, .instr_kind, .instr_int_num, .exc_ready, .arith_valid, .arith_group,
    .arith_ovf, .fetch_valid, .fetch_addr, .reti_valid, .reti_u, .reti_i, .reti_ipl,
    .periph_req, .periph_ack, .wdt_req, .osc_stop_req, .vmon1_req, .vmon2_req, .vec_req,
    .vec_addr, .vec_ack, .vec_data, .branch_valid, .branch_addr, .stack_push_u, .stack_sel,
    .ovf_flag, .irq_enable);
  iex_vec_mem iex_vec_mem_i (.aclk, .aresetn, .slow, .vec_req, .vec_addr, .vec_ack, .vec_data);

  always #5 aclk = ~aclk;

  task print_verdict;
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tmo;
    bad_count++;
    $display("MISMATCH t=%0t wait ran out", $time);
    print_verdict;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    if (k == 50) tmo();
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task rd(input logic [7:0] a);
    int k;
    @(posedge aclk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    if (k == 50) tmo();
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task ins(input iex_instr_t kd, input logic [5:0] n);
    @(posedge aclk);
    instr_valid <= 1'h1;
    instr_kind <= kd;
    instr_int_num <= n;
  endtask

  // Sources drop together, as a core and peripherals would once served
  task rel;
    @(posedge aclk);
    instr_valid <= 1'h0;
    periph_req <= 32'h0;
    {vmon2_req, vmon1_req, osc_stop_req, wdt_req} <= 4'h0;
    fetch_valid <= 1'h0;
  endtask

  task quiet(input int n);
    repeat (n) begin
      @(posedge aclk);
      #1;
      chk(vec_req, 32'h0);
    end
  endtask

  task trap(input logic [19:0] ea);
    int k;
    k = 0;
    do begin
      @(posedge aclk);
      #1;
      k++;
    end while (vec_req !== 1'h1 && k < 40);
    if (vec_req !== 1'h1) tmo();
    ackv = periph_ack;
    chk(vec_addr, ea);
    rel();
    for (k = 0; k < 40; k++) begin
      #1;
      if (branch_valid === 1'h1) break;
      @(posedge aclk);
    end
    if (k == 40) tmo();
    chk(branch_addr, ea ^ 20'h0f0f0);
  endtask

  task reti(input logic u, input logic i, input logic [2:0] p);
    @(posedge aclk);
    reti_valid <= 1'h1;
    reti_u <= u;
    reti_i <= i;
    reti_ipl <= p;
    @(posedge aclk);
    reti_valid <= 1'h0;
    #1;
    chk(stack_sel, u);
    chk(irq_enable, i);
  endtask

  task arith(input iex_arith_t g, input logic o, input logic e);
    @(posedge aclk);
    arith_valid <= 1'h1;
    arith_group <= g;
    arith_ovf <= o;
    @(posedge aclk);
    arith_valid <= 1'h0;
    #1;
    chk(ovf_flag, e);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    #1;
    chk({exc_ready, irq_enable, ovf_flag, stack_sel}, 32'h8);
    wr(OFS_VTB, 32'h3000);
    rd(OFS_VTB);
    chk(rdat, 32'h3000);
    rd(8'h40);
    chk(resp, RESP_SLVERR);
    chk(rdat, 32'h0);
    wr(8'h44, 32'h5);
    chk(resp, RESP_SLVERR);
    ins(IK_UND, 6'h0);
    trap(FIX_VEC_BASE);
    ins(IK_BRK, 6'h0);
    trap(20'h0ffe4);
    ins(IK_INTO, 6'h0);
    quiet(4);
    rel();
    for (int g = 1; g <= 10; g++) arith(iex_arith_t'(4'(g)), ~g[0], ~g[0]);
    arith(AG_OTHER, 1'h0, 1'h1);
    ins(IK_INTO, 6'h0);
    trap(20'h0ffe0);
    slow <= 1'h1;
    foreach (nums[j]) begin
      reti(1'h1, 1'h0, 3'h0);
      ins(IK_INT, 6'(nums[j]));
      trap(20'h3000 + 20'(nums[j] * 4));
      chk(stack_sel, nums[j] > 31);
      chk(stack_push_u, 32'h1);
    end
    slow <= 1'h0;
    for (int s = 0; s < 4; s++) begin
      @(posedge aclk);
      {vmon2_req, vmon1_req, osc_stop_req, wdt_req} <= 4'(1 << s);
      trap(20'h0fff0);
    end
    wr(OFS_LVL + 8'h4, 32'h333);
    @(posedge aclk);
    periph_req[8] <= 1'h1;
    quiet(4);
    rel();
    reti(1'h0, 1'h1, 3'h0);
    @(posedge aclk);
    periph_req[10:9] <= 2'h3;
    trap(20'h3024);
    chk(ackv, 32'h200);
    wr(OFS_LVL + 8'h4, 32'h503);
    reti(1'h0, 1'h1, 3'h0);
    @(posedge aclk);
    periph_req <= 32'h500;
    trap(20'h3028);
    reti(1'h0, 1'h1, 3'h5);
    @(posedge aclk);
    periph_req[10] <= 1'h1;
    quiet(4);
    rel();
    wr(OFS_MAA, 32'h11110);
    wr(OFS_MAB, 32'h23456);
    wr(OFS_AMEN, 32'h2);
    @(posedge aclk);
    fetch_valid <= 1'h1;
    fetch_addr <= 20'h11110;
    quiet(3);
    @(posedge aclk);
    fetch_addr <= 20'h23456;
    trap(20'h0ffe8);
    rd(OFS_STAT);
    chk(rdat, 32'h2500);
    print_verdict;
  end
endmodule
